/* File: design/pasl_top.v */
`timescale 1ns/1ps
`include "pasl_defs.vh"
// ****************************************************************
// Strap and status indicator pins
// ****************************************************************
module pasl_top #(
   parameter [`PASL_CNT_W-1:0] STRETCH_CYC = `PASL_STRETCH_CYC
) (
   input  wire       core_clk_in,
   input  wire       reset_in,
   input  wire       soft_reset_in,
   input  wire       collision_in,
   input  wire       link_valid_in,
   input  wire       addr1_collision_indicator_in,
   output wire       addr1_collision_indicator_out,
   output wire       addr1_collision_indicator_oe_n_out,
   input  wire       addr2_link_indicator_in,
   output wire       addr2_link_indicator_out,
   output wire       addr2_link_indicator_oe_n_out,
   output wire [2:1] strap_addr_out,
   output wire       strap_valid_out
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   localparam [1:0] ST_STRAP = 2'h0;
   localparam [1:0] ST_SHOW  = 2'h1;
   reg  [1:0] pin_s1_r;
   reg  [1:0] pin_s2_r;
   reg  [1:0] state_r;
   reg  [1:0] state_nxt;
   reg  [2:1] addr_r;
   reg  [2:1] addr_nxt;
   reg        col_pin_r;
   reg        col_pin_nxt;
   reg        link_pin_r;
   reg        link_pin_nxt;
   reg        col_en_r;
   reg        col_en_nxt;
   reg        link_en_r;
   reg        link_en_nxt;
   wire       col_active;
   wire       col_strap;
   wire       link_strap;
   // ****************************************************************
   // Indicator level
   // ****************************************************************
   // The lit level is the inverse of the strap so the lamp in series
   // with the strap resistor glows when the status is asserted.
   function pin_level;
      input asserted;
      input strap;
      begin
         pin_level = asserted ? ~strap : strap;
      end
   endfunction
   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   always @(posedge core_clk_in) begin
      pin_s1_r <= {addr2_link_indicator_in, addr1_collision_indicator_in};
      pin_s2_r <= pin_s1_r;
   end
   assign col_strap  = pin_s2_r[0];
   assign link_strap = pin_s2_r[1];
   // ****************************************************************
   // Collision stretcher
   // ****************************************************************
   pasl_stretch #(
      .STRETCH_CYC (STRETCH_CYC)
   ) u_col (
      .core_clk_in (core_clk_in),
      .reset_in    (reset_in),
      .event_in    (collision_in),
      .active_out  (col_active)
   );
   // ****************************************************************
   // Output drive
   // ****************************************************************
   // Capture happens on the first clock after release, from synchronised
   // levels taken while the pins were still undriven inputs.
   // Soft reset is deliberately not used here; pins stay outputs.
   always @* begin
      state_nxt    = state_r;
      addr_nxt     = addr_r;
      col_en_nxt   = col_en_r;
      link_en_nxt  = link_en_r;
      col_pin_nxt  = col_pin_r;
      link_pin_nxt = link_pin_r;
      case (state_r)
         ST_STRAP: begin
            addr_nxt[`PASL_ADDR_COL_BIT]  = col_strap;
            addr_nxt[`PASL_ADDR_LINK_BIT] = link_strap;
            col_en_nxt   = 1'b1;
            link_en_nxt  = 1'b1;
            col_pin_nxt  = pin_level(1'b1, col_strap);
            link_pin_nxt = pin_level(1'b1, link_strap);
            state_nxt    = ST_SHOW;
         end
         ST_SHOW: begin
            col_en_nxt   = 1'b1;
            link_en_nxt  = 1'b1;
            col_pin_nxt  = pin_level(col_active, addr_r[`PASL_ADDR_COL_BIT]);
            link_pin_nxt = pin_level(link_valid_in, addr_r[`PASL_ADDR_LINK_BIT]);
         end
         default: begin
            state_nxt = ST_STRAP;
         end
      endcase
   end
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         state_r    <= ST_STRAP;
         col_en_r   <= 1'b0;
         link_en_r  <= 1'b0;
         col_pin_r  <= 1'b0;
         link_pin_r <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         addr_r     <= addr_nxt;
         col_en_r   <= col_en_nxt;
         link_en_r  <= link_en_nxt;
         col_pin_r  <= col_pin_nxt;
         link_pin_r <= link_pin_nxt;
      end
   end
   assign addr1_collision_indicator_out      = col_en_r ? col_pin_r : 1'b0;
   assign addr2_link_indicator_out           = link_en_r ? link_pin_r : 1'b0;
   assign addr1_collision_indicator_oe_n_out = ~col_en_r;
   assign addr2_link_indicator_oe_n_out      = ~link_en_r;
   assign strap_addr_out                     = col_en_r ? addr_r : 2'h0;
   assign strap_valid_out                    = col_en_r;
endmodule

/* File: design/pasl_defs.vh */
`ifndef PASL_DEFS_VH
`define PASL_DEFS_VH
// ****************************************************************
// Timing
// ****************************************************************
`define PASL_CLK_HZ        10000000
`define PASL_STRETCH_MS    70
// Seventy milliseconds of the ten megahertz clock, sized to the counter width.
`define PASL_STRETCH_CYC   20'hAAE60
`define PASL_CNT_W         20
// ****************************************************************
// Address bit positions
// ****************************************************************
`define PASL_ADDR_COL_BIT  1
`define PASL_ADDR_LINK_BIT 2
`endif

/* File: design/pasl_stretch.v */
`timescale 1ns/1ps
`include "pasl_defs.vh"
// ****************************************************************
// Pulse stretcher
// ****************************************************************
module pasl_stretch #(
   parameter [`PASL_CNT_W-1:0] STRETCH_CYC = `PASL_STRETCH_CYC
) (
   input  wire core_clk_in,
   input  wire reset_in,
   input  wire event_in,
   output wire active_out
);
   reg  [`PASL_CNT_W-1:0] cnt_r;
   reg  [`PASL_CNT_W-1:0] cnt_nxt;
   // Each new event retriggers the full period so a burst stays lit.
   always @* begin
      cnt_nxt = cnt_r;
      if (event_in) begin
         cnt_nxt = STRETCH_CYC;
      end else if (cnt_r != {`PASL_CNT_W{1'b0}}) begin
         cnt_nxt = cnt_r - {{(`PASL_CNT_W-1){1'b0}}, 1'b1};
      end
   end
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         cnt_r <= {`PASL_CNT_W{1'b0}};
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
   assign active_out = (cnt_r != {`PASL_CNT_W{1'b0}});
endmodule

/* File: bench/pasl_board.sv */
`timescale 1ns/1ps
module pasl_board (input wire oe_n_in, drv_in, pull_in, output wire pin_out);
   assign pin_out = oe_n_in ? pull_in : drv_in;
endmodule

/* File: bench/pasl_top_props.sv */
`timescale 1ns/1ps
module pasl_top_props #(parameter [19:0] STRETCH_CYC = 20'h14) (
   input wire       core_clk_in, reset_in, soft_reset_in, collision_in, link_valid_in,
   input wire       addr1_collision_indicator_in, addr1_collision_indicator_out,
   input wire       addr1_collision_indicator_oe_n_out, addr2_link_indicator_in,
   input wire       addr2_link_indicator_out, addr2_link_indicator_oe_n_out, strap_valid_out,
   input wire [2:1] strap_addr_out
);
   reg [19:0] cnt_r;
   // Every collision reloads the count, so a burst keeps the lamp lit.
   always @(posedge core_clk_in) begin
      cnt_r <= reset_in ? 20'h0 : collision_in ? STRETCH_CYC : cnt_r - {19'h0, |cnt_r};
   end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   property p_rst_dir; disable iff (1'h0) reset_in && $past(reset_in) |->
      addr1_collision_indicator_oe_n_out && addr2_link_indicator_oe_n_out; endproperty
   property p_rst_drv; disable iff (1'h0) reset_in && $past(reset_in) |-> !strap_valid_out &&
      !addr1_collision_indicator_out && !addr2_link_indicator_out; endproperty
   property p_valid; !$past(reset_in) |-> strap_valid_out; endproperty
   property p_oe; strap_valid_out |->
      !addr1_collision_indicator_oe_n_out && !addr2_link_indicator_oe_n_out; endproperty
   property p_cap; $rose(strap_valid_out) |-> strap_addr_out ==
      {$past(addr2_link_indicator_in), $past(addr1_collision_indicator_in)}; endproperty
   property p_hold; strap_valid_out |=> $stable(strap_addr_out); endproperty
   property p_link; $past(strap_valid_out) |-> addr2_link_indicator_out ==
      ($past(link_valid_in) ^ strap_addr_out[2]); endproperty
   property p_col; $past(strap_valid_out) |-> addr1_collision_indicator_out ==
      (($past(cnt_r) != 20'h0) ^ strap_addr_out[1]); endproperty
   a_rst_dir: assert property (p_rst_dir) else $error("pin not released");
   a_rst_drv: assert property (p_rst_drv) else $error("drive in reset");
   a_valid: assert property (p_valid) else $error("no capture");
   a_oe: assert property (p_oe) else $error("pin not driven");
   a_cap: assert property (p_cap) else $error("bad strap");
   a_hold: assert property (p_hold) else $error("strap moved");
   a_link: assert property (p_link) else $error("bad link pin");
   a_col: assert property (p_col) else $error("bad collision pin");
   c_col: cover property (collision_in && strap_valid_out);
   c_cap: cover property ($rose(strap_valid_out));
   c_soft: cover property (soft_reset_in && strap_valid_out);
endmodule
bind pasl_top pasl_top_props #(.STRETCH_CYC(STRETCH_CYC)) u_props (.*);

/* File: bench/pasl_top_tb.sv */
`timescale 1ns/1ps
module pasl_top_tb;
   localparam [19:0] S = 20'h14;
   reg        core_clk_in = 0, reset_in = 1, soft_reset_in = 0, collision_in = 0;
   reg        link_valid_in = 0, e1, e2;
   reg  [2:1] pull_r = 2'h0;
   wire       addr1_collision_indicator_in, addr1_collision_indicator_out;
   wire       addr1_collision_indicator_oe_n_out, addr2_link_indicator_in;
   wire       addr2_link_indicator_out, addr2_link_indicator_oe_n_out, strap_valid_out;
   wire [2:1] strap_addr_out;
   integer    failures = 0, n_tests = 0, seed = 62208, c, i, k;
   pasl_top #(.STRETCH_CYC(S)) u_pasl_top (.*);
   pasl_board u_board1 (.oe_n_in(addr1_collision_indicator_oe_n_out), .pull_in(pull_r[1]),
      .drv_in(addr1_collision_indicator_out), .pin_out(addr1_collision_indicator_in));
   pasl_board u_board2 (.oe_n_in(addr2_link_indicator_oe_n_out), .pull_in(pull_r[2]),
      .drv_in(addr2_link_indicator_out), .pin_out(addr2_link_indicator_in));
   always #50 core_clk_in = ~core_clk_in;
   task chk(input [2:0] g, input [2:0] e); begin
      n_tests = n_tests + 1;
      if (g !== e) begin
         failures = failures + 1;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   end endtask
   task report_and_stop; begin
      $display("failures %0d n_tests %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   end endtask
   initial begin #(4 * 92 * 300); failures = failures + 1; report_and_stop; end
   initial begin
      for (k = 0; k < 4; k = k + 1) begin
         @(negedge core_clk_in);
         reset_in = 1; pull_r = k; collision_in = 0; link_valid_in = 0;
         repeat (10) @(negedge core_clk_in);
         chk({strap_valid_out, addr1_collision_indicator_oe_n_out,
            addr2_link_indicator_oe_n_out}, 3'h3);
         reset_in = 0;
         @(negedge core_clk_in);
         chk({1'h0, strap_addr_out}, {1'h0, pull_r});
         c = 0;
         for (i = 0; i < 80; i = i + 1) begin
            collision_in = ($random(seed) & 15) == 0;
            link_valid_in = $random(seed);
            soft_reset_in = $random(seed);
            @(posedge core_clk_in);
            e1 = (c != 0) ^ pull_r[1];
            e2 = link_valid_in ^ pull_r[2];
            c = collision_in ? S : c - (c != 0);
            @(negedge core_clk_in);
            chk({addr1_collision_indicator_oe_n_out | addr2_link_indicator_oe_n_out,
               addr1_collision_indicator_out, addr2_link_indicator_out},
               {1'h0, e1, e2});
         end
      end
      report_and_stop;
   end
endmodule
